// ### dual_clock_field_fifo.sv
// Purpose: Field memory FIFO with independent write and read pin ports.
// Assumes: Pin signals meet setup and hold around their clock edge and hold
//          long enough to pass the two-stage synchronisers with that edge.
// Notes:   Pin clocks are sampled, not used as clocks; each rising edge is an enable.
// Notes on behaviour
// - Holds 262224 eight-bit words and returns them first in, first out.
// - Write and read ports run together on unrelated clocks.
// - Storage refreshes itself without help and without disturbing either port.
// - Input byte is taken at the write clock edge starting the cycle.
// - Read byte appears after the read clock edge on a three-state output.
// - Write clear sampled on the write clock edge resets the write address.
// - Read clear sampled on the read clock edge resets the read address.
// - Write gate high: no write, write pointer holds.
// - Write gate low: byte written and write pointer advances that cycle.
// - Read gate high: read pointer holds, reading pauses.
// - Read gate low: word read and read pointer advances that cycle.
// - Drive control high puts all read data lines in high impedance; wrRoom stays driven.
// - Drive control never affects the read pointer.
// - Full 64-word write staging moves to the array; pointer returns to 0.
// - Emptied read staging loads the next 64-word block; pointer returns to 0.
// - First 80 words after a clear live in a static buffer.
// - Write row counter advances per block and wraps after the last row.
// - Clear is accepted while gated; it acts when gating ends.
// - Transfer starts at address 0 in the clear cycle itself.
`timescale 1ns/10ps

module field_write_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   // Filling side
   input  wire logic             inValid,
   output logic                  inReady,
   input  wire logic [WIDTH-1:0] inData,
   // Draining side
   output logic                  outValid,
   input  wire logic             outReady,
   output logic [WIDTH-1:0]      outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] store [0:DEPTH-1];
   logic [AW-1:0]    head_q;
   logic [AW-1:0]    tail_q;
   logic [AW:0]      count_q;
   wire              push = inValid && inReady;
   wire              pop  = outValid && outReady;

   // Flags straight from the occupancy count
   assign inReady  = (count_q != (AW+1)'(DEPTH));
   assign outValid = (count_q != '0);
   assign outData  = store[head_q];

   // Storage writes need no reset
   always_ff @(posedge sys_clk) begin
      if (push) begin
         store[tail_q] <= inData;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         head_q  <= '0;
         tail_q  <= '0;
         count_q <= '0;
      end else begin
         if (push) tail_q <= AW'(tail_q + 1'b1);
         if (pop)  head_q <= AW'(head_q + 1'b1);
         count_q <= (AW+1)'(count_q + push - pop);
      end
   end
endmodule // field_write_fifo

module dual_clock_field_fifo
   import field_fifo_pkg::*;
#(
   parameter int FIFO_WORDS = field_fifo_pkg::FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic                        sys_clk,
   input  wire logic                        reset_n,
   // Write port pins
   input  wire logic [field_fifo_pkg::WORD_W-1:0] in_byte,
   input  wire logic                        wr_clk,
   input  wire logic                        wr_clear_n,
   input  wire logic                        wr_gate_n,
   // Read port pins
   input  wire logic                        rd_clk,
   input  wire logic                        rd_clear_n,
   input  wire logic                        rd_gate_n,
   input  wire logic                        drive_on_n,
   // Read data, split three-state pin
   output logic [field_fifo_pkg::WORD_W-1:0] out_byte,
   output logic                        outByteOe_n,
   // Write path status
   output logic                        wrRoom
);
   import field_fifo_pkg::*;

   // Advance one word through staging, blocks and the static buffer
   function automatic ptr_t nextPtr(input ptr_t p);
      ptr_t n;
      n = p;
      if (p.inSram) begin
         if (p.sramIdx == SIDX_W'(SRAM_WORDS - 1)) begin
            n.inSram = 1'b0;
            n.row    = '0;
            n.col    = '0;
         end else begin
            n.sramIdx = SIDX_W'(p.sramIdx + 1'b1);
         end
      end else if (p.col == COL_W'(BLOCK_WORDS - 1)) begin
         n.col = '0;
         n.row = ROW_W'(p.row + 1'b1);
         if (p.row == ROW_W'(ROWS - 1)) n = PTR_ZERO;
      end else begin
         n.col = COL_W'(p.col + 1'b1);
      end
      return n;
   endfunction

   logic [WORD_W-1:0] arrayMem [0:ROWS*BLOCK_WORDS-1];
   logic [WORD_W-1:0] sramMem  [0:SRAM_WORDS-1];

   wrPins_t wrSync1_q, wrSync2_q;
   rdPins_t rdSync1_q, rdSync2_q;
   logic    wrClkOld_q, rdClkOld_q;
   ptr_t    wrPtr_q, rdPtr_q;
   logic    wrPend_q, rdPend_q;
   logic    refBusy_q;
   logic [REF_CNT_W-1:0] refCnt_q;
   logic [ROW_W-1:0]     refRow_q;

   // Two flops on every pin before use
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         wrSync1_q <= '0;
         wrSync2_q <= '0;
         rdSync1_q <= '0;
         rdSync2_q <= '0;
         wrClkOld_q <= 1'b0;
         rdClkOld_q <= 1'b0;
      end else begin
         wrSync1_q <= '{clk: wr_clk, clearN: wr_clear_n, gateN: wr_gate_n, data: in_byte};
         wrSync2_q <= wrSync1_q;
         rdSync1_q <= '{clk: rd_clk, clearN: rd_clear_n, gateN: rd_gate_n, driveN: drive_on_n};
         rdSync2_q <= rdSync1_q;
         wrClkOld_q <= wrSync2_q.clk;
         rdClkOld_q <= rdSync2_q.clk;
      end
   end

   // Pin clock edges become one-cycle enables
   wire  wrEdge   = wrSync2_q.clk && !wrClkOld_q;
   wire  rdEdge   = rdSync2_q.clk && !rdClkOld_q;
   wire  wrClear  = !wrSync2_q.clearN || wrPend_q;
   wire  rdClear  = !rdSync2_q.clearN || rdPend_q;
   wire  ptr_t wrAt = wrClear ? PTR_ZERO : wrPtr_q;
   wire  ptr_t rdAt = rdClear ? PTR_ZERO : rdPtr_q;
   wire  wrDo     = wrEdge && !wrSync2_q.gateN;
   wire  rdDo     = rdEdge && !rdSync2_q.gateN;

   // Write pointer: own edge, gate and clear only
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         wrPtr_q  <= PTR_ZERO;
         wrPend_q <= 1'b0;
      end else if (wrEdge) begin
         if (wrSync2_q.gateN) begin
            if (!wrSync2_q.clearN) wrPend_q <= 1'b1;
         end else begin
            wrPtr_q  <= nextPtr(wrAt);
            wrPend_q <= 1'b0;
         end
      end
   end

   // Write words queue for the array; a refresh slot may stall draining
   memWrite_t pushWord, popWord;
   logic      fifoInReady, popValid;
   assign pushWord = '{ptr: wrAt, data: wrSync2_q.data};
   field_write_fifo #(
      .WIDTH ($bits(memWrite_t)),
      .DEPTH (FIFO_WORDS)
   ) u_wrFifo (
      .sys_clk  (sys_clk),
      .reset_n  (reset_n),
      .inValid  (wrDo),
      .inReady  (fifoInReady),
      .inData   (pushWord),
      .outValid (popValid),
      .outReady (!refBusy_q),
      .outData  (popWord)
   );
   wire [ROW_W+COL_W-1:0] popIdx = {popWord.ptr.row, popWord.ptr.col};
   wire [ROW_W+COL_W-1:0] refIdx = {refRow_q, COL_W'(0)};

   // Array write port; refresh restores one row cell in its own slot
   always_ff @(posedge sys_clk) begin
      if (refBusy_q) begin
         arrayMem[refIdx] <= arrayMem[refIdx];
      end else if (popValid && !popWord.ptr.inSram) begin
         arrayMem[popIdx] <= popWord.data;
      end
      if (!refBusy_q && popValid && popWord.ptr.inSram) begin
         sramMem[popWord.ptr.sramIdx] <= popWord.data;
      end
   end

   // Refresh timer and row counter, invisible at the pins
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         refCnt_q  <= '0;
         refBusy_q <= 1'b0;
         refRow_q  <= '0;
      end else begin
         refBusy_q <= (refCnt_q == REF_CNT_W'(REFRESH_CYC - 1));
         refCnt_q  <= (refCnt_q == REF_CNT_W'(REFRESH_CYC - 1)) ? '0
                      : REF_CNT_W'(refCnt_q + 1'b1);
         if (refBusy_q) refRow_q <= ROW_W'(refRow_q + 1'b1);
      end
   end

   // Read pointer, independent of the drive control
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rdPtr_q  <= PTR_ZERO;
         rdPend_q <= 1'b0;
      end else if (rdEdge) begin
         if (rdSync2_q.gateN) begin
            if (!rdSync2_q.clearN) rdPend_q <= 1'b1;
         end else begin
            rdPtr_q  <= nextPtr(rdAt);
            rdPend_q <= 1'b0;
         end
      end
   end

   // Output word and drivers; an unread word stays on the lines
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         out_byte    <= OUT_RESET;
         outByteOe_n <= 1'b1;
         wrRoom      <= 1'b1;
      end else begin
         wrRoom <= fifoInReady;
         if (rdEdge) outByteOe_n <= rdSync2_q.driveN;
         if (rdDo) begin
            out_byte <= rdAt.inSram ? sramMem[rdAt.sramIdx]
                        : arrayMem[{rdAt.row, rdAt.col}];
         end
      end
   end

   // Checks on pointer, driver and refresh behaviour
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence wrGatedEdge;  wrEdge && wrSync2_q.gateN;  endsequence
   sequence wrOpenEdge;   wrEdge && !wrSync2_q.gateN; endsequence
   sequence rdGatedEdge;  rdEdge && rdSync2_q.gateN;  endsequence
   sequence rdOpenEdge;   rdEdge && !rdSync2_q.gateN; endsequence

   wrPtr_hold_a: assert property (wrGatedEdge |=> $stable(wrPtr_q))
      else $error("write pointer moved while gated");
   wrPtr_step_a: assert property (wrOpenEdge and !wrClear |=> wrPtr_q != $past(wrPtr_q))
      else $error("write pointer did not advance");
   wrClear_zero_a: assert property (wrOpenEdge and !wrSync2_q.clearN
      |=> wrPtr_q.inSram && wrPtr_q.sramIdx == 7'h01)
      else $error("write clear did not start at address 0");
   rdClear_zero_a: assert property (rdOpenEdge and !rdSync2_q.clearN
      |=> rdPtr_q.inSram && rdPtr_q.sramIdx == 7'h01)
      else $error("read clear did not start at address 0");
   rdPtr_hold_a: assert property (rdGatedEdge |=> $stable(rdPtr_q))
      else $error("read pointer moved while gated");
   drive_off_a: assert property (rdEdge && rdSync2_q.driveN |=> outByteOe_n)
      else $error("outputs driven while drive control high");
   rd_keeps_a: assert property (rdOpenEdge and rdSync2_q.driveN and !rdClear
      |=> rdPtr_q != $past(rdPtr_q))
      else $error("read pointer stalled by drive control");
   // A gated clear must be remembered, then used at the next open edge
   pend_clear_a: assert property (wrGatedEdge and !wrSync2_q.clearN |=> wrPend_q)
      else $error("gated write clear was lost");
   pend_apply_a: assert property (wrOpenEdge and wrPend_q
      |=> wrPtr_q.inSram && wrPtr_q.sramIdx == 7'h01 && !wrPend_q)
      else $error("pending write clear not applied");
   rdPend_set_a: assert property (rdGatedEdge and !rdSync2_q.clearN |=> rdPend_q)
      else $error("gated read clear was lost");
   block_wrap_a: assert property (wrOpenEdge and !wrClear and !wrPtr_q.inSram
      and wrPtr_q.col == 6'h3F |=> wrPtr_q.col == 6'h00)
      else $error("write staging did not return to 0");
   sram_leave_a: assert property (rdOpenEdge and !rdClear and rdPtr_q.inSram
      and rdPtr_q.sramIdx == 7'h4F |=> !rdPtr_q.inSram && rdPtr_q.row == 12'h000)
      else $error("static buffer did not hand over after 80 words");
   refresh_gap_a: assert property ($rose(refBusy_q) |=> !refBusy_q [*8])
      else $error("refresh slots too close");
endmodule // dual_clock_field_fifo

// ### field_fifo_pkg.sv
// Purpose: Shared constants and carrier types for the dual clock field FIFO.
// Assumes: Pin clocks run well below the 250 MHz system clock.
// Notes:   Array region is ROWS blocks of BLOCK_WORDS; a static front buffer precedes it.
package field_fifo_pkg;
   localparam int WORD_W      = 8;
   localparam int BLOCK_WORDS = 64;     // Staging register length
   localparam int SRAM_WORDS  = 80;     // Static buffer after a clear
   localparam int ROWS        = 4096;   // 80 + 4096*64 = 262224 words
   localparam int COL_W       = 6;
   localparam int ROW_W       = 12;
   localparam int SIDX_W      = 7;
   localparam int CLK_NS      = 4;
   localparam int REFRESH_NS  = 15600;  // Longest gap between row refreshes
   localparam int REFRESH_CYC = REFRESH_NS / CLK_NS;
   localparam int REF_CNT_W   = 12;
   localparam int FIFO_DEPTH  = 8;

   // Position of one word in the field
   typedef struct packed {
      logic              inSram;
      logic [SIDX_W-1:0] sramIdx;
      logic [ROW_W-1:0]  row;
      logic [COL_W-1:0]  col;
   } ptr_t;

   // Write port pins, sampled together
   typedef struct packed {
      logic              clk;
      logic              clearN;
      logic              gateN;
      logic [WORD_W-1:0] data;
   } wrPins_t;

   // Read port pins, sampled together
   typedef struct packed {
      logic clk;
      logic clearN;
      logic gateN;
      logic driveN;
   } rdPins_t;

   // One word on its way into storage
   typedef struct packed {
      ptr_t              ptr;
      logic [WORD_W-1:0] data;
   } memWrite_t;

   localparam ptr_t PTR_ZERO = '{inSram: 1'b1, sramIdx: '0, row: '0, col: '0};
   localparam logic [WORD_W-1:0] OUT_RESET = 8'h00;
endpackage

// ### field_video_partner.sv
// Purpose: Video logic model driving the write and read pin ports.
// Assumes: Pins change at the falling edge of the system clock.
// Notes:   Unequal half periods keep the two pin clocks unrelated.
`timescale 1ns/10ps

module field_video_partner
   import field_fifo_pkg::*;
#(
   parameter int WR_HALF = 4,
   parameter int RD_HALF = 5
) (
   // System clock used only for pacing
   input  wire logic                              sys_clk,
   // Write port
   output logic [field_fifo_pkg::WORD_W-1:0]      in_byte,
   output logic                                   wr_clk,
   output logic                                   wr_clear_n,
   output logic                                   wr_gate_n,
   // Read port
   output logic                                   rd_clk,
   output logic                                   rd_clear_n,
   output logic                                   rd_gate_n,
   output logic                                   drive_on_n
);
   import field_fifo_pkg::*;

   // Idle pins; clocks and data low, clears, gates and drive control high
   initial begin
      in_byte    = 8'h00;
      wr_clk     = 1'b0;
      wr_clear_n = 1'b1;
      wr_gate_n  = 1'b1;
      rd_clk     = 1'b0;
      rd_clear_n = 1'b1;
      rd_gate_n  = 1'b1;
      drive_on_n = 1'b1;
   end

   // One write pin cycle; data held to the edge, then scrambled
   task automatic wrCycle(input logic [WORD_W-1:0] data, input logic gateN,
                          input logic clearN);
      @(negedge sys_clk);
      in_byte    = data;
      wr_gate_n  = gateN;
      wr_clear_n = clearN;
      wr_clk     = 1'b1;
      repeat (WR_HALF) @(negedge sys_clk);
      wr_clk = 1'b0;
      repeat (WR_HALF - 1) @(negedge sys_clk);
      in_byte = ~data; // No stale byte after hold time
   endtask

   // One read pin cycle; output settled when it returns
   task automatic rdCycle(input logic gateN, input logic clearN, input logic driveN);
      @(negedge sys_clk);
      rd_gate_n  = gateN;
      rd_clear_n = clearN;
      drive_on_n = driveN;
      rd_clk     = 1'b1;
      repeat (RD_HALF) @(negedge sys_clk);
      rd_clk = 1'b0;
      repeat (RD_HALF - 1) @(negedge sys_clk);
   endtask
endmodule // field_video_partner

// ### tb_dual_clock_field_fifo.sv
// Purpose: Self-checking bench for the dual clock field FIFO.
// Assumes: Pin cycles slow enough for the two-stage pin sampling.
// Notes:   Read-back stops partway into the third 64-word block, short of the last word written.
`timescale 1ns/10ps

module tb_dual_clock_field_fifo;
   import field_fifo_pkg::*;

   logic                sysClk;
   logic                resetN;
   wire  [WORD_W-1:0]   inByte;
   wire                 wrClk, wrClearN, wrGateN;
   wire                 rdClk, rdClearN, rdGateN, driveOnN;
   logic [WORD_W-1:0]   outByte;
   logic                outByteOeN;
   logic                wrRoom;
   wire  [WORD_W-1:0]   outPin;
   int                  badCount;
   int                  checks;
   int                  wrCount;

   // Resolved level on the three-state data pins
   assign outPin = outByteOeN ? 8'hZZ : outByte;

   initial sysClk = 1'b0;
   always #2 sysClk = ~sysClk;

   field_video_partner #(.WR_HALF(4), .RD_HALF(5)) field_video_partner_i (
      .sys_clk(sysClk), .in_byte(inByte), .wr_clk(wrClk), .wr_clear_n(wrClearN),
      .wr_gate_n(wrGateN), .rd_clk(rdClk), .rd_clear_n(rdClearN),
      .rd_gate_n(rdGateN), .drive_on_n(driveOnN));

   dual_clock_field_fifo #(.FIFO_WORDS(FIFO_DEPTH)) dual_clock_field_fifo_i (
      .sys_clk(sysClk), .reset_n(resetN), .in_byte(inByte), .wr_clk(wrClk),
      .wr_clear_n(wrClearN), .wr_gate_n(wrGateN), .rd_clk(rdClk),
      .rd_clear_n(rdClearN), .rd_gate_n(rdGateN), .drive_on_n(driveOnN),
      .out_byte(outByte), .outByteOe_n(outByteOeN), .wrRoom(wrRoom));

   // Word pattern; keeps neighbouring words distinct
   function automatic logic [WORD_W-1:0] pat(input int i);
      return i[7:0] ^ 8'h5A;
   endfunction

   task automatic check(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
      checks++;
      if (seen !== exp) begin
         badCount++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finishTest;
      $display("Comparisons %0d, mismatches %0d", checks, badCount);
      if (badCount == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic resetState;
      check(outByte, OUT_RESET);
      check({7'h00, outByteOeN}, 8'h01);
      check({7'h00, wrRoom}, 8'h01);
   endtask

   // Power-up: both clears, then 83 dummy cycles with both gates open
   task automatic powerUpInit;
      fork
         field_video_partner_i.wrCycle(8'h00, 1'b0, 1'b0);
         field_video_partner_i.rdCycle(1'b0, 1'b0, 1'b1);
      join
      repeat (83) begin
         fork
            field_video_partner_i.wrCycle(8'h11, 1'b0, 1'b1);
            field_video_partner_i.rdCycle(1'b0, 1'b1, 1'b1);
         join
      end
      check(outPin, 8'hZZ);
   endtask

   // Field write with cleared start and some gated cycles
   task automatic writeField;
      for (int i = 0; i < 300; i++) begin
         if (i % 37 == 20)
            field_video_partner_i.wrCycle(8'hEE, 1'b1, 1'b1);
         field_video_partner_i.wrCycle(pat(i), 1'b0, (i == 0) ? 1'b0 : 1'b1);
         wrCount++;
      end
      check({7'h00, wrRoom}, 8'h01);
   endtask

   // Reader trails the writer by 200 words
   task automatic readField;
      int n;
      for (n = 0; n < 4000 && wrCount < 200; n++) @(negedge sysClk);
      if (wrCount < 200) begin
         badCount++;
         finishTest;
      end else begin
         field_video_partner_i.rdCycle(1'b0, 1'b0, 1'b0);
         check(outPin, pat(0));
         for (int i = 1; i < 240; i++) begin
            if (i % 50 == 25) begin
               field_video_partner_i.rdCycle(1'b1, 1'b1, 1'b0);
               check(outPin, pat(i - 1));
            end
            field_video_partner_i.rdCycle(1'b0, 1'b1, 1'b0);
            check(outPin, pat(i));
         end
      end
   endtask

   // Drive off still advances the read pointer
   task automatic driveOff;
      field_video_partner_i.rdCycle(1'b0, 1'b1, 1'b1);
      check(outPin, 8'hZZ);
      field_video_partner_i.rdCycle(1'b0, 1'b1, 1'b0);
      check(outPin, pat(241));
   endtask

   // Clear given in a gated cycle acts at the next open cycle
   task automatic clearWhileGated;
      field_video_partner_i.rdCycle(1'b1, 1'b0, 1'b0);
      check(outPin, pat(241));
      field_video_partner_i.rdCycle(1'b0, 1'b1, 1'b0);
      check(outPin, pat(0));
      field_video_partner_i.rdCycle(1'b0, 1'b1, 1'b0);
      check(outPin, pat(1));
   endtask

   // Write clear given while gated lands the next open word at address 0
   task automatic writeClearGated;
      field_video_partner_i.wrCycle(8'hEE, 1'b1, 1'b0);
      field_video_partner_i.wrCycle(8'hC3, 1'b0, 1'b1);
      field_video_partner_i.rdCycle(1'b0, 1'b0, 1'b0);
      check(outPin, 8'hC3);
   endtask

   // Cuts a hang short
   initial begin
      repeat (100000) @(posedge sysClk);
      badCount++;
      finishTest;
   end

   initial begin
      badCount = 0;
      checks   = 0;
      wrCount  = 0;
      resetN   = 1'b0;
      repeat (10) @(negedge sysClk);
      resetN = 1'b1;
      resetState;
      powerUpInit;
      fork
         writeField;
         readField;
      join
      driveOff;
      clearWhileGated;
      writeClearGated;
      finishTest;
   end
endmodule // tb_dual_clock_field_fifo
